/* File: rtl/gcp_arbiter.sv */
// Purpose: Decides which source controls the power device gate.
// Assumes: All inputs are synchronous to CLK_SYS; report enables are static.
// Notes:   Latched status drives the gate one cycle after it is caught.
`timescale 1ns/10ps
`default_nettype none
module gcp_arbiter (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        ISOLATED_FAILSAFE_PIN,
  input  wire logic        OSCILLATOR_LOSS_FAULT,
  input  wire logic        CROSS_DOMAIN_WATCHDOG_FAULT,
  input  wire logic        TIMING_REPORT_EN,
  input  wire logic        RESET_MODE_BIT,
  input  wire logic        BUILTIN_SELFTEST_BIT,
  input  wire logic [9:0]  HV_FAULT_DETECT,
  input  wire logic [9:0]  HV_FAULT_REPORT_EN,
  input  wire logic        UNDERVOLTAGE_LATCH_OPTION,
  input  wire logic        DESATURATION_FAULT,
  input  wire logic        SHORT_CIRCUIT_FAULT,
  input  wire logic        SEGMENTED_DRIVE_MODIFIER,
  input  wire logic        CLAMP_DETECT,
  input  wire logic        CLAMP_REPORT_EN,
  input  wire logic        OVERCURRENT_DETECT,
  input  wire logic        OVERCURRENT_REPORT_EN,
  input  wire logic        FAILSAFE_ENABLE_BIT,
  input  wire logic        FAILSAFE_STATE_BIT,
  input  wire logic        CONFIG_ENABLE_PIN,
  input  wire logic [8:0]  LV_FAULT_DETECT,
  input  wire logic [8:0]  LV_FAULT_REPORT_EN,
  input  wire logic        DEADTIME_VIOLATION,
  input  wire logic        DEADTIME_REPORT_EN,
  input  wire logic [7:0]  DEADTIME_SETTING,
  input  wire logic        PWM_PIN,
  input  wire logic        POWER_DEVICE_OVERTEMP_WARNING,
  input  wire logic        TEMP_WARN_REPORT_EN,
  input  wire logic        HV_POWER_ON,
  input  wire logic        LV_POWER_ON,
  input  wire logic        SERIAL_FRAME_ERROR,
  input  wire logic        FRAME_ERROR_REPORT_EN,
  input  wire logic        FAULT_CLEAR,
  output logic             GATE_ON,
  output logic [3:0]       ACTIVE_LEVEL,
  output logic             SHUTDOWN_MOD,
  output logic             TURNON_MOD,
  output logic [28:0]      FAULT_STATUS
);
  // ----------------------------------------------------------------
  // Latched status
  // ----------------------------------------------------------------
  logic [28:0] det_vec;
  logic [28:0] rep_vec;
  logic [28:0] stat;
  logic [9:0]  hv_det;

  // A non-latching regulator undervoltage is kept out of the latch.
  always_comb begin
    hv_det = HV_FAULT_DETECT;
    if (!UNDERVOLTAGE_LATCH_OPTION) hv_det[gcp_pkg::HV_REG_UV] = 1'b0;
  end

  assign det_vec = {SERIAL_FRAME_ERROR, LV_POWER_ON, HV_POWER_ON,
                    POWER_DEVICE_OVERTEMP_WARNING, DEADTIME_VIOLATION,
                    LV_FAULT_DETECT,
                    OVERCURRENT_DETECT, CLAMP_DETECT,
                    SHORT_CIRCUIT_FAULT, DESATURATION_FAULT,
                    hv_det,
                    OSCILLATOR_LOSS_FAULT | CROSS_DOMAIN_WATCHDOG_FAULT};
  assign rep_vec = {FRAME_ERROR_REPORT_EN, 2'b00, TEMP_WARN_REPORT_EN, DEADTIME_REPORT_EN,
                    LV_FAULT_REPORT_EN, OVERCURRENT_REPORT_EN, CLAMP_REPORT_EN, 2'b00,
                    HV_FAULT_REPORT_EN, TIMING_REPORT_EN};

  gcp_latch_bank #(
    .W      (gcp_pkg::STAT_W),
    .UNMASK (gcp_pkg::UNMASKABLE)
  ) u_bank (
    .clk    (CLK_SYS),
    .rstn   (RSTN),
    .det    (det_vec),
    .report (rep_vec),
    .clear  (FAULT_CLEAR),
    .lat    (stat)
  );

  // ----------------------------------------------------------------
  // Level requests
  // ----------------------------------------------------------------
  wire [28:0] gate_faults = stat & gcp_pkg::FAULT_BITS;
  wire        gated_uv    = !UNDERVOLTAGE_LATCH_OPTION &&
                            HV_FAULT_DETECT[gcp_pkg::HV_REG_UV] &&
                            HV_FAULT_REPORT_EN[gcp_pkg::HV_REG_UV];
  wire        req_hv      = (|gate_faults[gcp_pkg::POS_HV +: gcp_pkg::HV_W]) || gated_uv;
  wire        req_sat     = gate_faults[gcp_pkg::POS_SAT] || gate_faults[gcp_pkg::POS_SHORT];
  wire        req_lv      = |gate_faults[gcp_pkg::POS_LV +: gcp_pkg::LV_W];
  wire        req_fs      = !FAILSAFE_ENABLE_BIT;
  wire [13:0] req_vec;
  wire [3:0]  win_lvl;

  // The segment, overcurrent and deadtime modifier levels never command the gate, so their slots stay idle.
  assign req_vec = {1'b1,
                    1'b0,
                    req_lv,
                    CONFIG_ENABLE_PIN, req_fs,
                    1'b0,
                    gate_faults[gcp_pkg::POS_CLAMP],
                    1'b0,
                    req_sat,
                    req_hv,
                    BUILTIN_SELFTEST_BIT, RESET_MODE_BIT,
                    gate_faults[gcp_pkg::POS_TIMING],
                    ISOLATED_FAILSAFE_PIN};

  gcp_prio_enc #(
    .N     (gcp_pkg::NUM_LEVELS)
  ) u_enc (
    .req   (req_vec),
    .level (win_lvl)
  );

  // ----------------------------------------------------------------
  // Deadtime turn-on delay
  // ----------------------------------------------------------------
  logic [7:0] dt_cnt_r;
  logic [7:0] dt_cnt_nxt;
  // The count is compared with >= so that lowering the setting in mid-pulse
  // cannot push the count past the setting and keep the gate off until it wraps.
  wire        dt_done = (dt_cnt_r >= DEADTIME_SETTING);
  wire        pwm_eff = PWM_PIN && dt_done;

  assign dt_cnt_nxt = !PWM_PIN ? gcp_pkg::DT_CNT_RESET :
                      dt_done  ? dt_cnt_r : 8'(dt_cnt_r + 8'h01);

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) dt_cnt_r <= gcp_pkg::DT_CNT_RESET;
    else       dt_cnt_r <= dt_cnt_nxt;
  end

  // ----------------------------------------------------------------
  // Gate decision
  // ----------------------------------------------------------------
  logic gate_nxt;
  wire  sd_src  = SEGMENTED_DRIVE_MODIFIER || CLAMP_DETECT || OVERCURRENT_DETECT;
  wire  sd_nxt  = sd_src && (win_lvl != gcp_pkg::LVL_ISOLATE);
  wire  ton_nxt = (win_lvl == gcp_pkg::LVL_PWM) && PWM_PIN && !dt_done;

  // Fault levels above fail-safe override it whatever came first.
  always_comb begin
    case (win_lvl)
      gcp_pkg::LVL_FAILSAFE: gate_nxt = FAILSAFE_STATE_BIT;
      gcp_pkg::LVL_PWM:      gate_nxt = pwm_eff;
      default:               gate_nxt = 1'b0;
    endcase
  end

  logic       gate_r;
  logic [3:0] lvl_r;
  logic       sd_r;
  logic       ton_r;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      gate_r <= 1'b0;
      lvl_r  <= gcp_pkg::LVL_NONE;
      sd_r   <= 1'b0;
      ton_r  <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      lvl_r  <= win_lvl;
      sd_r   <= sd_nxt;
      ton_r  <= ton_nxt;
    end
  end

  assign GATE_ON      = gate_r;
  assign ACTIVE_LEVEL = lvl_r;
  assign SHUTDOWN_MOD = sd_r;
  assign TURNON_MOD   = ton_r;
  assign FAULT_STATUS = stat;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  property p_iso;
    ISOLATED_FAILSAFE_PIN |=> !GATE_ON && ACTIVE_LEVEL == 4'h1;
  endproperty
  a_iso: assert property (p_iso) else $error("isolation pin did not win");

  property p_timing;
    (stat[0] && !ISOLATED_FAILSAFE_PIN) |=> ACTIVE_LEVEL == 4'h2 && !GATE_ON;
  endproperty
  a_timing: assert property (p_timing) else $error("timing fault not level 2");

  property p_reset;
    (RESET_MODE_BIT && !ISOLATED_FAILSAFE_PIN && !stat[0]) |=> ACTIVE_LEVEL == 4'h3;
  endproperty
  a_reset: assert property (p_reset) else $error("reset bit not level 3");

  property p_hv;
    (win_lvl == 4'h5) |=> !GATE_ON;
  endproperty
  a_hv: assert property (p_hv) else $error("high side fault let gate on");

  property p_gated;
    (!UNDERVOLTAGE_LATCH_OPTION && HV_FAULT_DETECT[1] && HV_FAULT_REPORT_EN[1] && !stat[2])
      |=> !GATE_ON && ACTIVE_LEVEL <= 4'h5 && !stat[2];
  endproperty
  a_gated: assert property (p_gated) else $error("gated undervoltage latched");

  property p_sat;
    (DESATURATION_FAULT || SHORT_CIRCUIT_FAULT) |=> ##1 (!GATE_ON || ISOLATED_FAILSAFE_PIN
      || ACTIVE_LEVEL < 4'h6);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation fault let gate on");

  property p_fs;
    (win_lvl == 4'hA) |=> GATE_ON == $past(FAILSAFE_STATE_BIT);
  endproperty
  a_fs: assert property (p_fs) else $error("gate not at fail-safe state");

  property p_pwm;
    (win_lvl == 4'hE) |=> GATE_ON == $past(pwm_eff) && ACTIVE_LEVEL == 4'hE;
  endproperty
  a_pwm: assert property (p_pwm) else $error("gate not following PWM");

  property p_hold;
    !FAULT_CLEAR |=> (stat & $past(stat)) == $past(stat);
  endproperty
  a_hold: assert property (p_hold) else $error("latched status dropped");

  property p_mask;
    (!TEMP_WARN_REPORT_EN && !stat[25]) |=> !stat[25];
  endproperty
  a_mask: assert property (p_mask) else $error("masked warning latched");

  property p_seg;
    (SEGMENTED_DRIVE_MODIFIER && !ISOLATED_FAILSAFE_PIN)
      |=> SHUTDOWN_MOD && ACTIVE_LEVEL != 4'h7;
  endproperty
  a_seg: assert property (p_seg) else $error("segmented drive not shaping");

  property p_clamp_mask;
    (CLAMP_DETECT && !CLAMP_REPORT_EN && !stat[gcp_pkg::POS_CLAMP] && !ISOLATED_FAILSAFE_PIN)
      |=> SHUTDOWN_MOD && !stat[gcp_pkg::POS_CLAMP];
  endproperty
  a_clamp_mask: assert property (p_clamp_mask) else $error("masked clamp wrong");

  property p_clamp_latch;
    (CLAMP_DETECT && CLAMP_REPORT_EN) |=> stat[gcp_pkg::POS_CLAMP];
  endproperty
  a_clamp_latch: assert property (p_clamp_latch) else $error("clamp not latched");

  property p_oc;
    (OVERCURRENT_DETECT && OVERCURRENT_REPORT_EN && !ISOLATED_FAILSAFE_PIN)
      |=> SHUTDOWN_MOD && stat[gcp_pkg::POS_OC_WARN];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent response wrong");

  property p_warn;
    (gate_faults == 29'h00000000 && !gated_uv && !ISOLATED_FAILSAFE_PIN && !RESET_MODE_BIT &&
     !BUILTIN_SELFTEST_BIT && FAILSAFE_ENABLE_BIT && !CONFIG_ENABLE_PIN) |=> ACTIVE_LEVEL == 4'hE;
  endproperty
  a_warn: assert property (p_warn) else $error("warning changed gate control");

  property p_fs_rank;
    !FAILSAFE_ENABLE_BIT |=> ACTIVE_LEVEL != 4'h0 && ACTIVE_LEVEL <= 4'hA;
  endproperty
  a_fs_rank: assert property (p_fs_rank) else $error("fail-safe outranked");

  property p_cfg;
    CONFIG_ENABLE_PIN |=> ACTIVE_LEVEL <= 4'hB && (ACTIVE_LEVEL == 4'hA || !GATE_ON);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config pin outranked");

  property p_lv;
    (|gate_faults[gcp_pkg::POS_LV +: gcp_pkg::LV_W])
      |=> ACTIVE_LEVEL <= 4'hC && (ACTIVE_LEVEL == 4'hA || !GATE_ON);
  endproperty
  a_lv: assert property (p_lv) else $error("low side fault let gate on");

  property p_dt;
    (win_lvl == 4'hE && $rose(PWM_PIN) && DEADTIME_SETTING != 8'h00) |=> TURNON_MOD && !GATE_ON;
  endproperty
  a_dt: assert property (p_dt) else $error("deadtime not enforced");

  property p_dt_warn;
    (!DEADTIME_REPORT_EN && !stat[gcp_pkg::POS_DT_WARN]) |=> !stat[gcp_pkg::POS_DT_WARN];
  endproperty
  a_dt_warn: assert property (p_dt_warn) else $error("masked deadtime latched");

  property p_prio;
    (win_lvl != gcp_pkg::LVL_FAILSAFE && win_lvl != gcp_pkg::LVL_PWM) |=> !GATE_ON;
  endproperty
  a_prio: assert property (p_prio) else $error("winning level let gate on");

  c_fs_after_fault: cover property (stat[11] ##1 !FAILSAFE_ENABLE_BIT);
  c_pwm_gate:       cover property (win_lvl == 4'hE && pwm_eff ##1 GATE_ON);
  c_deadtime:       cover property (TURNON_MOD ##[1:20] GATE_ON);
  c_clear:          cover property ((|stat) ##1 FAULT_CLEAR ##1 stat == 29'h00000000);
  c_gated_uv:       cover property (gated_uv ##1 !GATE_ON);
endmodule // gcp_arbiter
`default_nettype wire

/* File: rtl/gcp_pkg.sv */
// Purpose: Shared constants for the gate control priority arbiter.
// Assumes: Fault status bits are laid out as one flat vector.
// Notes:   Report enable bits are active high: 1 lets a maskable source act.
package gcp_pkg;
  // ----------------------------------------------------------------
  // Priority levels
  // ----------------------------------------------------------------
  localparam int          NUM_LEVELS     = 14;
  localparam logic [3:0]  LVL_NONE       = 4'h0;
  localparam logic [3:0]  LVL_ISOLATE    = 4'h1;
  localparam logic [3:0]  LVL_TIMING     = 4'h2;
  localparam logic [3:0]  LVL_RESET      = 4'h3;
  localparam logic [3:0]  LVL_SELFTEST   = 4'h4;
  localparam logic [3:0]  LVL_HV_FAULT   = 4'h5;
  localparam logic [3:0]  LVL_SAT_FAULT  = 4'h6;
  localparam logic [3:0]  LVL_SEGMENT    = 4'h7;
  localparam logic [3:0]  LVL_CLAMP      = 4'h8;
  localparam logic [3:0]  LVL_OVERCUR    = 4'h9;
  localparam logic [3:0]  LVL_FAILSAFE   = 4'hA;
  localparam logic [3:0]  LVL_CONFIG     = 4'hB;
  localparam logic [3:0]  LVL_LV_FAULT   = 4'hC;
  localparam logic [3:0]  LVL_DEADTIME   = 4'hD;
  localparam logic [3:0]  LVL_PWM        = 4'hE;
  // ----------------------------------------------------------------
  // Fault status vector layout
  // ----------------------------------------------------------------
  localparam int          HV_W           = 10;
  localparam int          LV_W           = 9;
  localparam int          STAT_W         = 29;
  localparam int          POS_TIMING     = 0;
  localparam int          POS_HV         = 1;
  localparam int          HV_REG_UV      = 1;
  localparam int          POS_SAT        = 11;
  localparam int          POS_SHORT      = 12;
  localparam int          POS_CLAMP      = 13;
  localparam int          POS_OC_WARN    = 14;
  localparam int          POS_LV         = 15;
  localparam int          POS_DT_WARN    = 24;
  localparam int          POS_TEMP_WARN  = 25;
  localparam int          POS_POR_HV     = 26;
  localparam int          POS_POR_LV     = 27;
  localparam int          POS_FRAME_WARN = 28;
  // Bits that ignore their report enable.
  localparam logic [28:0] UNMASKABLE     = 29'h0C171A28;
  // Bits that change the gate when latched.
  localparam logic [28:0] FAULT_BITS     = 29'h00FFBFFF;
  localparam logic [28:0] STAT_RESET     = 29'h00000000;
  // ----------------------------------------------------------------
  // Deadtime
  // ----------------------------------------------------------------
  localparam int          DT_W           = 8;
  localparam logic [7:0]  DT_CNT_RESET   = 8'h00;
endpackage

/* File: rtl/gcp_latch_bank.sv */
// Purpose: Sticky latch bank for faults and warnings.
// Assumes: Clear is a one-cycle strobe; detections are levels.
// Notes:   A detection in the clear cycle stays latched.
`timescale 1ns/10ps
`default_nettype none
module gcp_latch_bank #(
  parameter int         W      = 29,
  parameter logic [W-1:0] UNMASK = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] det,
  input  wire logic [W-1:0] report,
  input  wire logic         clear,
  output logic      [W-1:0] lat
);
  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  logic [W-1:0] lat_r;
  logic [W-1:0] lat_nxt;
  wire  [W-1:0] allow = report | UNMASK;

  assign lat_nxt = (lat_r & ~{W{clear}}) | (det & allow);
  assign lat     = lat_r;

  always_ff @(posedge clk) begin
    if (!rstn) lat_r <= '0;
    else       lat_r <= lat_nxt;
  end
endmodule // gcp_latch_bank
`default_nettype wire

/* File: rtl/gcp_prio_enc.sv */
// Purpose: Finds the lowest numbered active priority level.
// Assumes: Bit k of the request vector stands for level k+1.
// Notes:   Returns zero when nothing requests.
`timescale 1ns/10ps
`default_nettype none
module gcp_prio_enc #(
  parameter int N = 14
) (
  input  wire logic [N-1:0] req,
  output logic      [3:0]   level
);
  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  function automatic logic [3:0] lowest(input logic [N-1:0] r);
    logic [3:0] v;
    v = 4'h0;
    for (int k = N - 1; k >= 0; k--) begin
      if (r[k]) v = 4'(k + 1);
    end
    return v;
  endfunction

  assign level = lowest(req);
endmodule // gcp_prio_enc
`default_nettype wire

/* File: sim/gcp_host_model.sv */
// Purpose: Host side model that drives the control pins and mode bits.
// Assumes: Callers enter its tasks just after a rising clock edge.
// Notes:   The idle state is normal mode with fail-safe enable high and every other control bit low.
`timescale 1ns/10ps
`default_nettype none
module gcp_host_model (
  input  wire logic clk,
  output var  logic rst_bit,
  output var  logic builtin_selftest_bit,
  output var  logic fs_enable,
  output var  logic fs_state,
  output var  logic cfg_pin,
  output var  logic pwm,
  output var  logic clear
);
  initial begin
    {rst_bit, builtin_selftest_bit, fs_enable, fs_state, cfg_pin, pwm} = 6'h08;
    clear = 1'b0;
  end
  // Bits are reset, self-test, fail-safe enable, fail-safe state, config pin, PWM.
  // Fail-safe may be entered whenever no higher level requests, a latched low side fault included.
  task automatic set_ctl(input logic [5:0] v);
    {rst_bit, builtin_selftest_bit, fs_enable, fs_state, cfg_pin, pwm} = v;
  endtask
  task automatic pulse_clear();
    clear = 1'b1;
    @(posedge clk);
    #1;
    clear = 1'b0;
  endtask
endmodule // gcp_host_model
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the gate control priority arbiter.
// Assumes: Inputs change 1 ns after a rising edge; outputs are read then.
// Notes:   Deadtime is 3 clocks in its own test and 0 elsewhere.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb;
  logic        clk, rstn, iso, osc, wdf, tim_en, uvl, desaturation_fault, shrt, seg, clamp, clamp_en;
  logic        oc, oc_en, dtv, dt_en, power_device_overtemp_warning, otw_en, hpor, lpor, sfe, sfe_en;
  logic        rst_bit, builtin_selftest_bit, fs_enable, fs_state, cfg_pin, pwm, clear, gate, sdm, tom;
  logic [9:0]  hv_det, hv_en;
  logic [8:0]  lv_det, lv_en;
  logic [7:0]  dts;
  logic [3:0]  lvl;
  logic [28:0] stat;
  int          error_cnt, total_checks, i;
  localparam logic [5:0] CTL [5] = '{6'h09, 6'h0B, 6'h03, 6'h13, 6'h33};
  localparam logic [3:0] LEV [5] = '{gcp_pkg::LVL_PWM, gcp_pkg::LVL_CONFIG,
    gcp_pkg::LVL_FAILSAFE, gcp_pkg::LVL_SELFTEST, gcp_pkg::LVL_RESET};
  gcp_host_model host (.clk(clk), .rst_bit(rst_bit), .builtin_selftest_bit(builtin_selftest_bit),
    .fs_enable(fs_enable), .fs_state(fs_state), .cfg_pin(cfg_pin), .pwm(pwm), .clear(clear));
  gcp_arbiter dut (
    .CLK_SYS                       (clk),
    .RSTN                          (rstn),
    .ISOLATED_FAILSAFE_PIN         (iso),
    .OSCILLATOR_LOSS_FAULT         (osc),
    .CROSS_DOMAIN_WATCHDOG_FAULT   (wdf),
    .TIMING_REPORT_EN              (tim_en),
    .RESET_MODE_BIT                (rst_bit),
    .BUILTIN_SELFTEST_BIT          (builtin_selftest_bit),
    .HV_FAULT_DETECT               (hv_det),
    .HV_FAULT_REPORT_EN            (hv_en),
    .UNDERVOLTAGE_LATCH_OPTION     (uvl),
    .DESATURATION_FAULT            (desaturation_fault),
    .SHORT_CIRCUIT_FAULT           (shrt),
    .SEGMENTED_DRIVE_MODIFIER      (seg),
    .CLAMP_DETECT                  (clamp),
    .CLAMP_REPORT_EN               (clamp_en),
    .OVERCURRENT_DETECT            (oc),
    .OVERCURRENT_REPORT_EN         (oc_en),
    .FAILSAFE_ENABLE_BIT           (fs_enable),
    .FAILSAFE_STATE_BIT            (fs_state),
    .CONFIG_ENABLE_PIN             (cfg_pin),
    .LV_FAULT_DETECT               (lv_det),
    .LV_FAULT_REPORT_EN            (lv_en),
    .DEADTIME_VIOLATION            (dtv),
    .DEADTIME_REPORT_EN            (dt_en),
    .DEADTIME_SETTING              (dts),
    .PWM_PIN                       (pwm),
    .POWER_DEVICE_OVERTEMP_WARNING (power_device_overtemp_warning),
    .TEMP_WARN_REPORT_EN           (otw_en),
    .HV_POWER_ON                   (hpor),
    .LV_POWER_ON                   (lpor),
    .SERIAL_FRAME_ERROR            (sfe),
    .FRAME_ERROR_REPORT_EN         (sfe_en),
    .FAULT_CLEAR                   (clear),
    .GATE_ON                       (gate),
    .ACTIVE_LEVEL                  (lvl),
    .SHUTDOWN_MOD                  (sdm),
    .TURNON_MOD                    (tom),
    .FAULT_STATUS                  (stat)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic out_chk(input logic g, input logic [3:0] l, input string m);
    `CHK(gate, g, m)
    `CHK(lvl, l, m)
  endtask
  // Drops every detection, clears the status and lets the gate recover.
  task automatic settle();
    {osc, wdf, desaturation_fault, shrt, seg, clamp, oc, dtv, power_device_overtemp_warning, hpor, lpor, sfe} = '0;
    hv_det = '0;
    lv_det = '0;
    host.pulse_clear();
    tick(1);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    {iso, osc, wdf, desaturation_fault, shrt, seg, clamp, oc, dtv, power_device_overtemp_warning, hpor, lpor, sfe} = '0;
    {tim_en, clamp_en, oc_en, dt_en, otw_en, sfe_en, uvl} = 7'h7F;
    {hv_det, lv_det, hv_en, lv_en} = {19'h00000, 19'h7FFFF};
    {dts, rstn, error_cnt, total_checks} = {8'h03, 1'b0, 32'h0, 32'h0};
    tick(8);
    out_chk(1'b0, gcp_pkg::LVL_NONE, "reset outputs");
    `CHK(stat, gcp_pkg::STAT_RESET, "reset status")
    rstn = 1'b1;
    tick(1);
    host.set_ctl(6'h09);
    tick(1);
    `CHK(tom, 1'b1, "turn-on modifier")
    tick(2);
    out_chk(1'b0, gcp_pkg::LVL_PWM, "deadtime hold");
    tick(1);
    out_chk(1'b1, gcp_pkg::LVL_PWM, "pwm steers gate");
    `CHK(tom, 1'b0, "modifier ends")
    dts = 8'h00;
    desaturation_fault = 1'b1;
    tick(1);
    `CHK(stat[gcp_pkg::POS_SAT], 1'b1, "desaturation_fault latched")
    tick(1);
    desaturation_fault = 1'b0;
    out_chk(1'b0, gcp_pkg::LVL_SAT_FAULT, "desaturation_fault gate");
    tick(3);
    out_chk(1'b0, gcp_pkg::LVL_SAT_FAULT, "fault held");
    host.pulse_clear();
    `CHK(stat, gcp_pkg::STAT_RESET, "status cleared")
    tick(1);
    out_chk(1'b1, gcp_pkg::LVL_PWM, "gate back");
    hv_en = '0;
    hv_det = 10'h001;
    tick(2);
    `CHK(stat, gcp_pkg::STAT_RESET, "masked ignored")
    hv_det = 10'h005;
    tick(2);
    `CHK(stat[gcp_pkg::POS_HV+2], 1'b1, "unmaskable hv")
    out_chk(1'b0, gcp_pkg::LVL_HV_FAULT, "hv level");
    settle();
    hv_en = '1;
    lv_en = '0;
    lv_det = 9'h003;
    tick(2);
    `CHK(stat[gcp_pkg::POS_LV+1:gcp_pkg::POS_LV], 2'h2, "lv mask")
    out_chk(1'b0, gcp_pkg::LVL_LV_FAULT, "lv level");
    settle();
    lv_en = '1;
    tim_en = 1'b0;
    osc = 1'b1;
    tick(2);
    out_chk(1'b1, gcp_pkg::LVL_PWM, "timing masked");
    tim_en = 1'b1;
    wdf = 1'b1;
    tick(2);
    `CHK(stat[gcp_pkg::POS_TIMING], 1'b1, "timing latched")
    out_chk(1'b0, gcp_pkg::LVL_TIMING, "timing level");
    settle();
    uvl = 1'b0;
    hv_det = 10'h002;
    tick(1);
    out_chk(1'b0, gcp_pkg::LVL_HV_FAULT, "gated uv");
    hv_det = 10'h000;
    tick(1);
    `CHK(stat, gcp_pkg::STAT_RESET, "gated uv unlatched")
    out_chk(1'b1, gcp_pkg::LVL_PWM, "gated uv ends");
    uvl = 1'b1;
    {clamp_en, clamp} = 2'h1;
    tick(2);
    `CHK({sdm, gate, stat[gcp_pkg::POS_CLAMP]}, 3'h6, "masked clamp")
    {clamp, seg} = 2'h1;
    tick(1);
    `CHK({sdm, gate}, 2'h3, "segmented drive")
    {seg, oc} = 2'h1;
    tick(2);
    `CHK({sdm, gate, stat[gcp_pkg::POS_OC_WARN]}, 3'h7, "overcurrent")
    {oc, clamp_en, clamp} = 3'h3;
    tick(2);
    `CHK(stat[gcp_pkg::POS_CLAMP], 1'b1, "clamp latched")
    out_chk(1'b0, gcp_pkg::LVL_CLAMP, "clamp level");
    settle();
    {otw_en, sfe_en, dt_en} = 3'h0;
    {power_device_overtemp_warning, hpor, lpor, sfe, dtv} = 5'h1F;
    tick(2);
    `CHK(stat, 29'h0C000000, "masked warnings")
    {otw_en, sfe_en, dt_en} = 3'h7;
    tick(2);
    `CHK(stat, 29'h1F000000, "warnings")
    out_chk(1'b1, gcp_pkg::LVL_PWM, "warnings no gate");
    {power_device_overtemp_warning, hpor, lpor, sfe, dtv} = 5'h00;
    rstn = 1'b0;
    tick(1);
    out_chk(1'b0, gcp_pkg::LVL_NONE, "mid-run reset");
    `CHK({sdm, tom, stat}, 31'h00000000, "mid-run reset status")
    rstn = 1'b1;
    tick(1);
    out_chk(1'b1, gcp_pkg::LVL_PWM, "after reset");
    for (i = 0; i < 2; i++) begin
      if (i == 0) lv_det = 9'h001;
      else host.set_ctl(6'h05);
      tick(2);
      if (i == 0) host.set_ctl(6'h05);
      else lv_det = 9'h001;
      tick(2);
      out_chk(1'b1, gcp_pkg::LVL_FAILSAFE, "fail-safe order");
      host.set_ctl(6'h09);
      settle();
    end
    host.set_ctl(6'h07);
    tick(1);
    out_chk(1'b1, gcp_pkg::LVL_FAILSAFE, "fail-safe over config");
    for (i = 0; i < 5; i++) begin
      host.set_ctl(CTL[i]);
      tick(1);
      out_chk(i == 0, LEV[i], "priority ladder");
    end
    {iso, seg} = 2'h3;
    tick(1);
    out_chk(1'b0, gcp_pkg::LVL_ISOLATE, "isolation pin");
    `CHK(sdm, 1'b0, "modifier off under isolation")
    summarize();
  end
endmodule // tb
`default_nettype wire
